/* logic/wwd_pkg.sv */
// Constants, register map and timeout arithmetic of the window watchdog
package wwd_pkg;

	// Clock and reset pulse timing
	localparam int CLK_PERIOD_NS = 50; // 20 MHz oscillator clock
	localparam int RST_PULSE_NS = 30000; // Reset pin low time, typical
	localparam int RST_PULSE_CYC_I =
		(RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 10; // Holds RST_PULSE_CYC
	localparam logic [RST_CNT_W-1:0] RST_PULSE_CYC =
		RST_CNT_W'(RST_PULSE_CYC_I);

	// Prescaler: one counter decrement per PRESC_DIV oscillator periods
	localparam int PRESC_DIV = 16384;
	localparam int PRESC_W = 14;

	// Restart delays after wake-up, in oscillator clocks
	localparam int DLY_W = 13;
	localparam logic [DLY_W-1:0] DLY_SHORT = 13'h0100; // 256
	localparam logic [DLY_W-1:0] DLY_LONG = 13'h1000; // 4096

	// Avalon word byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00; // wdog_control_reg
	localparam logic [4:0] OFS_WINDOW = 5'h04; // wdog_window_reg
	localparam logic [4:0] OFS_CONFIG = 5'h08; // Timebase and halt options
	localparam logic [4:0] OFS_STATUS = 5'h0c; // Live state
	localparam logic [4:0] OFS_TMIN = 5'h10; // Minimum timeout, periods
	localparam logic [4:0] OFS_TMAX = 5'h14; // Maximum timeout, periods

	// Field positions
	localparam int CTRL_ACT_BIT = 7; // activation_bit
	localparam int CTRL_TOP_BIT = 6; // counter_top_bit
	localparam int CFG_TB_LO = 0; // timebase_select[1:0]
	localparam int CFG_OIE_BIT = 2; // rtc_irq_enable
	localparam int CFG_WHALT_BIT = 3; // halt_reset_option

	// Reset values and counter thresholds
	localparam logic [6:0] CNT_RESET = 7'h7f;
	localparam logic [6:0] WIN_RESET = 7'h7f;
	localparam logic [6:0] CNT_LAST_SAFE = 7'h40; // Next step clears top
	localparam logic [6:0] CNT_MAX_LOW = 7'h3f;

	// Timeout relation constants
	localparam int TMIN_ADD = 128;
	localparam int FINE_MUL = 64;
	localparam int TICK_PERIODS = 16384;
	localparam int SHORT_ADD = 192;

	// Coarse constant of the selected timebase
	function automatic int wwd_coarse(input logic [1:0] tb);
		case (tb)
			2'h0: return 4;
			2'h1: return 8;
			2'h2: return 20;
			default: return 49;
		endcase
	endfunction

	// Fine constant of the selected timebase
	function automatic int wwd_fine(input logic [1:0] tb);
		case (tb)
			2'h0: return 59;
			2'h1: return 53;
			2'h2: return 35;
			default: return 54;
		endcase
	endfunction

	// Timeout in oscillator periods; divisions truncate
	function automatic logic [31:0] wwd_timeout(input logic [5:0] cnt,
		input logic [1:0] tb, input logic is_max);
		int c;
		int ms;
		int ls;
		int k;
		int base;
		logic short_path;
		c = int'(cnt);
		ms = wwd_coarse(tb);
		ls = wwd_fine(tb);
		k = (4 * c) / ms;
		base = is_max ? TICK_PERIODS : (ls + TMIN_ADD) * FINE_MUL;
		short_path = is_max ? (c <= ms / 4) : (c < ms / 4);
		if (short_path)
			return 32'(base + TICK_PERIODS * c);
		return 32'(base + TICK_PERIODS * (c - k) +
			(SHORT_ADD + ls) * FINE_MUL * k);
	endfunction

endpackage

/* logic/wwd_prescaler.sv */
// Free-running prescaler that paces the watchdog counter
`timescale 1ns/100ps
`default_nettype none
module wwd_prescaler #(
	parameter int DIV = wwd_pkg::PRESC_DIV // Periods per tick
) (
	input wire logic sys_clk, // Oscillator clock
	input wire logic rstn, // Async reset, active low
	output logic tick // One-cycle decrement enable
);
	import wwd_pkg::*;

	logic [PRESC_W-1:0] div_reg; // Phase counter
	logic [PRESC_W-1:0] div_next;
	logic tick_reg;
	logic tick_next;

	// Never cleared by register writes, so the first tick after a
	// reload falls anywhere inside one period
	always_comb begin
		tick_next = (div_reg == PRESC_W'(DIV - 1));
		div_next = tick_next ? '0 : div_reg + 1'b1;
	end

	// State registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule
`default_nettype wire

/* logic/wwd_delay.sv */
// Restart delay timer used after wake-up from halt
`timescale 1ns/100ps
`default_nettype none
module wwd_delay (
	input wire logic sys_clk, // Oscillator clock
	input wire logic rstn, // Async reset, active low
	input wire logic start, // Pulse: begin a delay
	input wire logic long_sel, // 1: long delay, 0: short
	output logic done // Pulse when the delay ends
);
	import wwd_pkg::*;

	logic [DLY_W-1:0] cnt_reg; // Remaining clocks
	logic [DLY_W-1:0] cnt_next;
	logic done_reg;
	logic done_next;

	// Load on start, count down to zero, flag the last step
	always_comb begin
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (start)
			cnt_next = long_sel ? DLY_LONG : DLY_SHORT;
		else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
			done_next = (cnt_reg == DLY_W'(1));
		end
	end

	// State registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
endmodule
`default_nettype wire

/* logic/wwd_top.sv */
// Window watchdog with timeout calculator and low-power handling
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module wwd_top #(
	parameter int TICK_DIV = wwd_pkg::PRESC_DIV // Periods per decrement
) (
	input wire logic sys_clk, // 20 MHz oscillator clock
	input wire logic rstn, // Async reset, active low
	input wire logic [4:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Holds the master
	input wire logic hw_wdog_option, // Strap: always active
	input wire logic restart_long_sel, // Strap: 4096 vs 256 clocks
	input wire logic halted_before_reset, // Strap: woke by reset
	input wire logic halt_exec, // Pulse: halt instruction
	input wire logic wake_irq, // Pulse: exit-from-halt interrupt
	output logic wdog_reset_n // Reset request, active low
);
	import wwd_pkg::*;

	// Slow and wait are not states here: the counter runs off the
	// oscillator clock, so a slower processor clock changes nothing
	typedef enum logic [2:0] {
		ST_RUN, // Normal counting, also slow and wait
		ST_HALT_ONCE, // Halt, one decrement still due
		ST_HALT_STOP, // Halt, counter frozen
		ST_ACT_HALT, // Active halt, counter frozen
		ST_WAKE_DLY // Waiting out the restart delay
	} wwd_state_e;

	// Power mode and counter state, each with its next value
	wwd_state_e state_reg;
	wwd_state_e state_next;
	logic [6:0] cnt_reg; // Downcounter
	logic [6:0] cnt_next;
	// Control, window and configuration fields
	logic act_reg; // Activation bit
	logic act_next;
	logic [6:0] win_reg; // Window value
	logic [6:0] win_next;
	logic [1:0] tb_reg; // timebase_select
	logic [1:0] tb_next;
	logic oie_reg; // rtc_irq_enable
	logic oie_next;
	logic whalt_reg; // halt_reset_option
	logic whalt_next;
	// Straps are held for the whole run once captured
	logic hw_opt_reg; // Captured strap
	logic hw_opt_next;
	logic strap_done_reg; // Straps taken
	logic strap_done_next;
	// Reset pulse stretcher and bus answer registers
	logic [RST_CNT_W-1:0] rst_cnt_reg; // Reset pulse remaining
	logic [RST_CNT_W-1:0] rst_cnt_next;
	logic rst_n_reg;
	logic rst_n_next;
	logic waitreq_reg;
	logic waitreq_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Internal strobes and combinational results
	logic tick; // Decrement enable
	logic dly_start; // Begin restart delay
	logic dly_done; // Restart delay over
	logic active; // Watchdog may reset
	logic wr_acc; // Write taken this edge
	logic wr_ctrl; // Control register write
	logic fire; // Reset request event
	logic [31:0] tmin; // Minimum timeout
	logic [31:0] tmax; // Maximum timeout

	// Decrement pacing; no reset from register writes.
	// A reload keeps the prescaler phase, which is why the first
	// step after a write lands anywhere inside one tick period
	wwd_prescaler #(
		.DIV(TICK_DIV)
	) u_presc (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick(tick)
	);

	// Restart delay after waking from halt
	// The delay length follows the strap level at its start
	wwd_delay u_dly (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.start(dly_start),
		.long_sel(restart_long_sel),
		.done(dly_done)
	);

	// Timeout figures for the current count and timebase; only the
	// low six bits count, bit 6 just keeps the counter above 3Fh.
	// The arithmetic is wide but feeds the read path alone
	always_comb begin
		tmin = wwd_timeout(cnt_reg[5:0], tb_reg, 1'b0);
		tmax = wwd_timeout(cnt_reg[5:0], tb_reg, 1'b1);
	end

	// Hardware option makes the watchdog permanently active
	// A write counts only at the edge where waitrequest is low
	assign active = act_reg | hw_opt_reg;
	assign wr_acc = avs_write && !waitreq_reg;
	assign wr_ctrl = wr_acc && (avs_address == OFS_CTRL);

	// Reset events; halt states suppress rollover resets.
	// Several causes may meet in one cycle; they all end in the
	// same pulse, so no priority between them is needed
	always_comb begin
		fire = 1'b0;
		if (active && tick && state_reg == ST_RUN &&
			cnt_reg == CNT_LAST_SAFE)
			fire = 1'b1;
		if (wr_ctrl) begin
			if (active && (cnt_reg >= win_reg || cnt_reg <= CNT_MAX_LOW))
				fire = 1'b1;
			if ((active || avs_writedata[CTRL_ACT_BIT]) &&
				!avs_writedata[CTRL_TOP_BIT])
				fire = 1'b1;
		end
		if (halt_exec && state_reg == ST_RUN && !oie_reg && whalt_reg)
			fire = 1'b1;
	end

	// Strap capture after reset release, and the delayed restart.
	// The option and halt straps are read once, at the first edge after release, so
	// a strap that moves later cannot switch the watchdog off
	always_comb begin
		hw_opt_next = hw_opt_reg;
		strap_done_next = 1'b1;
		dly_start = 1'b0;
		if (!strap_done_reg) begin
			hw_opt_next = hw_wdog_option;
			dly_start = halted_before_reset;
		end
		if (state_reg == ST_HALT_ONCE || state_reg == ST_HALT_STOP)
			dly_start = wake_irq;
	end

	// Power mode sequencing. Halt requests are only honoured in run;
	// a wake interrupt outside the halt states is ignored
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (!strap_done_reg && halted_before_reset)
					state_next = ST_WAKE_DLY;
				else if (halt_exec && oie_reg)
					state_next = ST_ACT_HALT;
				else if (halt_exec && !whalt_reg)
					state_next = ST_HALT_ONCE;
			end
			ST_HALT_ONCE: begin
				if (wake_irq)
					state_next = ST_WAKE_DLY;
				else if (tick)
					state_next = ST_HALT_STOP;
			end
			ST_HALT_STOP: begin
				if (wake_irq)
					state_next = ST_WAKE_DLY;
			end
			ST_ACT_HALT: begin
				if (wake_irq)
					state_next = ST_RUN;
			end
			ST_WAKE_DLY: begin
				if (dly_done)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
	end

	// Counter and register writes; a reload wins over a tick.
	// A tick in the halt-once state is the single step allowed before
	// the counter freezes; ticks in the other halt states are lost
	always_comb begin
		cnt_next = cnt_reg;
		act_next = act_reg;
		win_next = win_reg;
		tb_next = tb_reg;
		oie_next = oie_reg;
		whalt_next = whalt_reg;
		// Counts in slow and wait exactly as in run
		if (tick && (state_reg == ST_RUN || state_reg == ST_HALT_ONCE))
			cnt_next = cnt_reg - 1'b1;
		if (wr_ctrl) begin
			cnt_next = avs_writedata[6:0];
			// Only set here; cleared by reset alone
			act_next = act_reg | avs_writedata[CTRL_ACT_BIT];
		end
		if (wr_acc && avs_address == OFS_WINDOW)
			win_next = avs_writedata[6:0];
		if (wr_acc && avs_address == OFS_CONFIG) begin
			tb_next = avs_writedata[CFG_TB_LO +: 2];
			oie_next = avs_writedata[CFG_OIE_BIT];
			whalt_next = avs_writedata[CFG_WHALT_BIT];
		end
	end

	// Reset pulse stretcher; a new event restarts the pulse.
	// Restarting gives a late cause a full pulse of its own, so it
	// is never cut short by an earlier one
	always_comb begin
		rst_cnt_next = rst_cnt_reg;
		if (fire)
			rst_cnt_next = RST_PULSE_CYC;
		else if (rst_cnt_reg != '0)
			rst_cnt_next = rst_cnt_reg - 1'b1;
		// Low while any count remains, including the loading cycle
		rst_n_next = (rst_cnt_next == '0);
	end

	// Avalon slave: one wait state, then the answer.
	// Read data are captured while waitrequest is still high, so
	// they stand, registered, in the cycle of the answer and after
	always_comb begin
		waitreq_next = !((avs_read || avs_write) && waitreq_reg);
		rdata_next = rdata_reg;
		if (avs_read && waitreq_reg) begin
			case (avs_address)
				OFS_CTRL: rdata_next = {24'h000000, act_reg, cnt_reg};
				OFS_WINDOW: rdata_next = {25'h0000000, win_reg};
				OFS_CONFIG: rdata_next = {28'h0000000, whalt_reg,
					oie_reg, tb_reg};
				// Status collects live flags; nothing here is writable
				OFS_STATUS: rdata_next = {28'h0000000, !rst_n_reg,
					state_reg != ST_RUN, hw_opt_reg, active};
				OFS_TMIN: rdata_next = tmin;
				OFS_TMAX: rdata_next = tmax;
				default: rdata_next = 32'h00000000; // Unmapped
			endcase
		end
	end

	// State registers; the reset values leave the watchdog disabled
	// unless the hardware strap is captured after release
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_RUN;
			cnt_reg <= CNT_RESET;
			act_reg <= 1'b0;
			win_reg <= WIN_RESET;
			tb_reg <= 2'h0;
			oie_reg <= 1'b0;
			whalt_reg <= 1'b0;
			hw_opt_reg <= 1'b0;
			strap_done_reg <= 1'b0;
			rst_cnt_reg <= '0;
			rst_n_reg <= 1'b1;
			waitreq_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			act_reg <= act_next;
			win_reg <= win_next;
			tb_reg <= tb_next;
			oie_reg <= oie_next;
			whalt_reg <= whalt_next;
			hw_opt_reg <= hw_opt_next;
			strap_done_reg <= strap_done_next;
			rst_cnt_reg <= rst_cnt_next;
			rst_n_reg <= rst_n_next;
			waitreq_reg <= waitreq_next;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs come straight from flip-flops
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = waitreq_reg;
	assign wdog_reset_n = rst_n_reg;
endmodule
`default_nettype wire

/* bench/wwd_props.sv */
// Concurrent checks on the window watchdog's ports
`timescale 1ns/100ps
`default_nettype none
module wwd_props (
	input wire logic sys_clk, // Clock
	input wire logic rstn, // Reset, active low
	input wire logic [4:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Wait request
	input wire logic wdog_reset_n // Reset request out
);
	logic [9:0] low_reg; // Cycles of the current pulse
	logic [9:0] low_next; // Next pulse length
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Measure the pulse; saturation is not needed below 1024
	always_comb begin
		low_next = wdog_reset_n ? 10'h000 : low_reg + 10'h001;
	end
	// Register the pulse length
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_reg <= 10'h000;
		end else begin
			low_reg <= low_next;
		end
	end
	a_wait_once: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one cycle");
	a_wait_release: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait request low for more than one cycle");
	a_wait_idle: assert property (!(avs_read || avs_write) |=>
		avs_waitrequest) else $error("answer without a request");
	a_pulse_length: assert property ($rose(wdog_reset_n) |->
		low_reg >= 10'h258) else $error("reset pulse too short");
	a_top_clear: assert property (avs_write && !avs_waitrequest &&
		avs_address == 5'h00 && avs_writedata[7:6] == 2'h2 |=>
		!wdog_reset_n) else $error("no reset on cleared top bit");
	a_read_stable: assert property ($changed(avs_readdata) |->
		$past(avs_read && avs_waitrequest))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
		avs_address > 5'h14 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_window_upper: assert property (avs_read && !avs_waitrequest &&
		avs_address == 5'h04 |-> avs_readdata[31:7] == 25'h0)
		else $error("window upper bits not zero");
endmodule
bind wwd_top wwd_props u_props (.sys_clk(sys_clk), .rstn(rstn),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.wdog_reset_n(wdog_reset_n));
`default_nettype wire

/* bench/tb_wwd_top.sv */
// Self-checking testbench of the window watchdog
`timescale 1ns/100ps
`default_nettype none
module tb_wwd_top;
	import wwd_pkg::*;
	logic sys_clk = 1'h0; // Oscillator clock
	logic rstn = 1'h0; // Reset, active low
	logic [4:0] addr = 5'h00; // Bus address
	logic rd_req = 1'h0; // Read request
	logic wr_req = 1'h0; // Write request
	logic [31:0] wdata = 32'h0; // Write data
	logic [31:0] rdata; // Read data
	logic wreq; // Wait request
	logic hw_opt = 1'h0; // Hardware option strap
	logic long_sel = 1'h0; // Long restart delay
	logic woke_rst = 1'h0; // Reset came from halt
	logic halt_p = 1'h0; // Halt pulse
	logic wake_p = 1'h0; // Wake pulse
	logic wd_rst_n; // Reset request out
	logic [31:0] v; // Last value read
	int n_mismatch = 0;
	int tests_run = 0;
	wwd_top #(.TICK_DIV(64)) dut (.sys_clk(sys_clk), .rstn(rstn),
		.avs_address(addr), .avs_read(rd_req), .avs_write(wr_req),
		.avs_writedata(wdata), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .hw_wdog_option(hw_opt),
		.restart_long_sel(long_sel), .halted_before_reset(woke_rst),
		.halt_exec(halt_p), .wake_irq(wake_p), .wdog_reset_n(wd_rst_n));
	// 50 ns period
	always #25 sys_clk = ~sys_clk;
	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus cycle; held until wait request is sampled low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int i;
		addr <= a;
		wdata <= d;
		wr_req <= w;
		rd_req <= !w;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (wreq !== 1'h0 && i < 20);
		if (wreq !== 1'h0) begin
			n_mismatch++;
			report_and_stop();
		end
		v = rdata;
		wr_req <= 1'h0;
		rd_req <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [4:0] a);
		bus(1'h0, a, 32'h0);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	// One-cycle pulse on halt or wake
	task automatic pulse(input logic wake);
		wake_p <= wake;
		halt_p <= !wake;
		@(posedge sys_clk);
		wake_p <= 1'h0;
		halt_p <= 1'h0;
	endtask
	task automatic do_reset(input logic hw, input logic hb);
		rstn <= 1'h0;
		hw_opt <= hw;
		woke_rst <= hb;
		long_sel <= 1'h0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'h1;
		repeat (2) @(posedge sys_clk);
	endtask
	// Wait for a reset pulse, then measure its length
	task automatic expect_rst(input int bound);
		int i;
		i = 0;
		while (wd_rst_n !== 1'h0 && i < bound) begin
			@(posedge sys_clk);
			i++;
		end
		cmp(32'(wd_rst_n), 32'h0);
		if (wd_rst_n !== 1'h0) report_and_stop();
		i = 0;
		while (wd_rst_n === 1'h0 && i < 700) begin
			@(posedge sys_clk);
			i++;
		end
		cmp(32'(i), 32'h258);
		if (wd_rst_n === 1'h0) report_and_stop();
	endtask
	// Read until the counter steps, so a halt lands early in a tick
	task automatic sync_tick();
		logic [31:0] p;
		rd(OFS_CTRL);
		p = v;
		for (int i = 0; i < 40 && v === p; i++) rd(OFS_CTRL);
		if (v === p) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	// Own model of the timeout relations
	function automatic logic [31:0] tmo(input int c, input int t,
		input logic mx);
		int ms[4] = '{4, 8, 20, 49};
		int ls[4] = '{59, 53, 35, 54};
		int k;
		int b;
		k = 4 * c / ms[t];
		b = mx ? 16384 : (ls[t] + 128) * 64;
		if (mx ? c <= ms[t] / 4 : c < ms[t] / 4) return 32'(b + 16384 * c);
		return 32'(b + 16384 * (c - k) + (192 + ls[t]) * 64 * k);
	endfunction
	task automatic t_defaults();
		do_reset(1'h0, 1'h0);
		wr(5'h18, 32'hff);
		rd(5'h18);
		cmp(v, 32'h0);
		rd(OFS_WINDOW);
		cmp(v, 32'h7f);
		rd(OFS_CTRL);
		cmp(v & 32'h80, 32'h0);
		rd(OFS_STATUS);
		cmp(v & 32'h1, 32'h0);
	endtask
	// Active halt freezes the counter; timeouts for all timebases
	task automatic t_timeouts(input logic [31:0] c);
		logic [31:0] f;
		do_reset(1'h0, 1'h0);
		wr(OFS_CONFIG, 32'hc);
		wr(OFS_CTRL, c);
		pulse(1'h0);
		rd(OFS_CTRL);
		f = v;
		repeat (200) @(posedge sys_clk);
		rd(OFS_CTRL);
		cmp(v, f);
		cmp(32'(wd_rst_n), 32'h1);
		for (int t = 0; t < 4; t++) begin
			wr(OFS_CONFIG, 32'(12 + t));
			rd(OFS_TMIN);
			cmp(v, tmo(int'(f[5:0]), t, 1'h0));
			rd(OFS_TMAX);
			cmp(v, tmo(int'(f[5:0]), t, 1'h1));
		end
		pulse(1'h1);
		rd(OFS_STATUS);
		cmp(v & 32'h4, 32'h0);
		repeat (130) @(posedge sys_clk);
		rd(OFS_CTRL);
		cmp(32'(v[6:0] < f[6:0]), 32'h1);
	endtask
	// Plain halt: one decrement, frozen, delayed restart
	task automatic t_plain_halt(input logic l);
		logic [31:0] g;
		do_reset(1'h0, 1'h0);
		long_sel <= l;
		wr(OFS_CTRL, 32'hff);
		sync_tick();
		g = v - 32'h1;
		pulse(1'h0);
		repeat (200) @(posedge sys_clk);
		rd(OFS_CTRL);
		cmp(v, g);
		cmp(32'(wd_rst_n), 32'h1);
		pulse(1'h1);
		repeat (l ? 4036 : 196) @(posedge sys_clk);
		rd(OFS_STATUS);
		cmp(v & 32'h4, 32'h4);
		rd(OFS_CTRL);
		cmp(v, g);
		repeat (120) @(posedge sys_clk);
		rd(OFS_STATUS);
		cmp(v & 32'h4, 32'h0);
	endtask
	task automatic t_window();
		do_reset(1'h0, 1'h0);
		wr(OFS_WINDOW, 32'h50);
		wr(OFS_CTRL, 32'hff);
		cmp(32'(wd_rst_n), 32'h1);
		wr(OFS_CTRL, 32'hff);
		expect_rst(5);
	endtask
	task automatic t_resets();
		do_reset(1'h0, 1'h0);
		wr(OFS_CTRL, 32'hbf);
		expect_rst(5);
		do_reset(1'h0, 1'h0);
		wr(OFS_CONFIG, 32'h8);
		pulse(1'h0);
		expect_rst(5);
	endtask
	task automatic t_rollover();
		do_reset(1'h0, 1'h0);
		wr(OFS_CTRL, 32'hc1);
		wr(OFS_CTRL, 32'h41);
		rd(OFS_CTRL);
		cmp(v & 32'h80, 32'h80);
		cmp(32'(wd_rst_n), 32'h1);
		expect_rst(200);
	endtask
	task automatic t_straps();
		do_reset(1'h1, 1'h1);
		rd(OFS_STATUS);
		cmp(v & 32'h7, 32'h7);
		repeat (300) @(posedge sys_clk);
		rd(OFS_STATUS);
		cmp(v & 32'h4, 32'h0);
	endtask
	// Cuts a hang short
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		t_defaults();
		t_timeouts(32'h7f);
		t_timeouts(32'h4c);
		t_timeouts(32'h40);
		t_plain_halt(1'h0);
		t_plain_halt(1'h1);
		t_window();
		t_resets();
		t_rollover();
		t_straps();
		report_and_stop();
	end
endmodule
`default_nettype wire
